// [logic/async_serial_port.sv]
// Overview of operation
// - Disable finishes current character; reprogram while disabled
// - Send start, data LSB first, parity, stops
// - Check overrun, parity, framing, break; store flags
// - Divisor: 16-bit integer plus 6-bit fraction
// - Sixteen-times tick; divide by sixteen for transmit
// - Divisor and line settings load on line write
// - Sixteen-entry queues; send until transmit queue empty
// - Busy while queue non-empty or shifting
// - Accept start bit if low at eighth tick
// - Sample data and parity every sixteenth tick
// - Low stop sample is framing error; push character
// - Normal infrared: zero sends 3/16 high pulse
// - Low-power infrared pulse is three low-power ticks
// - Data read gives 12 bits; write pushes 8
// - Queues single-entry until queue enable set
// - Hardware empty, full and overrun flags
// - Thresholds 1/8 to 7/8, reset to half
// - All events ORed into one interrupt request
// - Mask gates events; raw readable; write-one clears
// - Receive event at threshold, clears below it
// - Transmit event at threshold, clears above it
// - Loopback routes transmit output into receiver
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "uart_defs.svh"
module async_serial_port
   import uart_pkg::*;
#(
   parameter int DEPTH = 16
)(
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   // Register port
   input  wire logic [11:0] addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   // Serial line and interrupt
   input  wire logic        serial_in_i,
   output logic             serial_out_o,
   output logic             irq_o
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;

   typedef struct packed {
      logic [9:0]             ctrl;
      logic [7:0]             line;
      logic [15:0]            divi;
      logic [5:0]             divf;
      logic [29:0]            cfg;
      logic [7:0]             ilp;
      logic [5:0]             thr;
      logic [6:0]             mask;
      logic [6:0]             raw;
      logic [3:0]             rstat;
      logic [DEPTH-1:0][7:0]  tx_mem;
      logic [PW-1:0]          tx_wp;
      logic [PW-1:0]          tx_rp;
      logic [CW-1:0]          tx_cnt;
      logic [DEPTH-1:0][11:0] rx_mem;
      logic [PW-1:0]          rx_wp;
      logic [PW-1:0]          rx_rp;
      logic [CW-1:0]          rx_cnt;
      logic [22:0]            acc;
      logic                   tick;
      logic [7:0]             lp_cnt;
      logic                   lp_tick;
      logic [1:0]             lp_left;
      tx_state_e              tx_st;
      logic [3:0]             tx_ph;
      logic [2:0]             tx_idx;
      logic [7:0]             tx_sh;
      logic                   tx_par;
      logic                   tx_bit;
      logic                   tx_stop2;
      rx_state_e              rx_st;
      logic [3:0]             rx_ph;
      logic [2:0]             rx_idx;
      logic [7:0]             rx_sh;
      logic                   rx_perr;
      logic                   ovr_pend;
      logic                   sync1;
      logic                   sync2;
      logic                   rx_prev;
      logic [4:0]             sir_hold;
      logic                   rx_cond;
      logic                   tx_cond;
      logic [9:0]             to_cnt;
      logic                   out;
      logic                   irq;
      logic [31:0]            rdata;
   } state_s;

   localparam state_s RST_S = '{ctrl: `CTRL_RST, thr: `THR_RST, tx_st: TX_IDLE, rx_st: RX_IDLE,
                                sync1: 1'b1, sync2: 1'b1, rx_prev: 1'b1, tx_bit: 1'b1, out: 1'b1, default: '0};

   state_s        s_q;
   state_s        s_d;
   logic [22:0]   acc_sum;
   logic [21:0]   div;
   logic [7:0]    lc;
   logic [6:0]    clr;
   logic [CW-1:0] depth_eff;
   logic [2:0]    wlast;
   logic [7:0]    wmask;
   logic          push_tx;
   logic          pop_tx;
   logic          push_rx;
   logic          pop_rx;
   logic          rx_line;
   logic          tx_line;
   logic          p_exp;
   logic          fe;
   logic          be;
   logic [3:0]    errs;

   // Threshold select to entry count; unknown codes fall back to half
   function automatic logic [CW-1:0] level_of(input logic [2:0] sel);
      logic [CW-1:0] l;
      case (sel)
         3'h0: l = CW'(DEPTH / 8);
         3'h1: l = CW'(DEPTH / 4);
         3'h3: l = CW'(DEPTH * 3 / 4);
         3'h4: l = CW'(DEPTH * 7 / 8);
         default: l = CW'(DEPTH / 2);
      endcase
      return l;
   endfunction

   // Whole next-state computation
   always_comb
   begin
      s_d = s_q;
      clr = '0;
      push_tx = 1'b0;
      pop_tx = 1'b0;
      push_rx = 1'b0;
      pop_rx = 1'b0;
      fe = 1'b0;
      be = 1'b0;
      errs = '0;
      div = s_q.cfg[29:8];
      lc = s_q.cfg[7:0];
      depth_eff = lc[`LC_FEN] ? CW'(DEPTH) : CW'(1);
      wlast = 3'(3'h4 + {1'b0, lc[`LC_WLEN+1:`LC_WLEN]});
      wmask = 8'hff >> (2'h3 - lc[`LC_WLEN+1:`LC_WLEN]);
      tx_line = s_q.tx_bit & ~lc[`LC_BRK];

      // Input synchroniser; only the second stage is used
      s_d.sync1 = serial_in_i;
      s_d.sync2 = s_q.sync1;

      // Fractional accumulator in 1/64 clock units gives the sixteen-times tick
      acc_sum = s_q.acc + `FRAC_STEP;
      s_d.tick = 1'b0;
      if (div != '0)
      begin
         if (acc_sum >= {1'b0, div})
         begin
            s_d.tick = 1'b1;
            s_d.acc = acc_sum - {1'b0, div};
         end
         else
            s_d.acc = acc_sum;
      end

      // Low-power infrared tick; divisor of zero divides by 256
      s_d.lp_tick = 1'b0;
      s_d.lp_cnt = s_q.lp_cnt + 8'h01;
      if (s_q.lp_cnt == 8'(s_q.ilp - 8'h01))
      begin
         s_d.lp_tick = 1'b1;
         s_d.lp_cnt = '0;
      end

      // Register writes
      if (wr_i)
      begin
         case (addr_i)
            `OFS_DATA:  push_tx = (s_q.tx_cnt < depth_eff);
            `OFS_RSTAT: s_d.rstat = '0;
            `OFS_ILP:   s_d.ilp = wdata_i[7:0];
            `OFS_DIVI:  s_d.divi = wdata_i[15:0];
            `OFS_DIVF:  s_d.divf = wdata_i[5:0];
            `OFS_LINE:
            begin
               s_d.line = wdata_i[7:0];
               s_d.cfg = {s_q.divi, s_q.divf, wdata_i[7:0]};
            end
            `OFS_CTRL:  s_d.ctrl = wdata_i[9:0];
            `OFS_THR:   s_d.thr = wdata_i[5:0];
            `OFS_MASK:  s_d.mask = wdata_i[6:0];
            `OFS_ICLR:  clr = wdata_i[6:0];
            default:    ;
         endcase
      end

      // Register reads; data stands for one cycle only
      s_d.rdata = '0;
      if (rd_i)
      begin
         case (addr_i)
            `OFS_DATA:
            begin
               s_d.rdata = {20'h0, s_q.rx_mem[s_q.rx_rp]};
               pop_rx = (s_q.rx_cnt != '0);
               if (pop_rx)
                  s_d.rstat = s_q.rx_mem[s_q.rx_rp][11:8];
            end
            `OFS_RSTAT: s_d.rdata = {28'h0, s_q.rstat};
            `OFS_FLAG:
            begin
               s_d.rdata[`FL_BUSY] = (s_q.tx_cnt != '0) || (s_q.tx_st != TX_IDLE);
               s_d.rdata[`FL_RX_EMPTY_FLAG] = (s_q.rx_cnt == '0);
               s_d.rdata[`FL_TX_FULL_FLAG] = (s_q.tx_cnt >= depth_eff);
               s_d.rdata[`FL_RX_FULL_FLAG] = (s_q.rx_cnt >= depth_eff);
               s_d.rdata[`FL_TX_EMPTY_FLAG] = (s_q.tx_cnt == '0);
            end
            `OFS_ILP:   s_d.rdata = {24'h0, s_q.ilp};
            `OFS_DIVI:  s_d.rdata = {16'h0, s_q.divi};
            `OFS_DIVF:  s_d.rdata = {26'h0, s_q.divf};
            `OFS_LINE:  s_d.rdata = {24'h0, s_q.line};
            `OFS_CTRL:  s_d.rdata = {22'h0, s_q.ctrl};
            `OFS_THR:   s_d.rdata = {26'h0, s_q.thr};
            `OFS_MASK:  s_d.rdata = {25'h0, s_q.mask};
            `OFS_RAW:   s_d.rdata = {25'h0, s_q.raw};
            `OFS_MIS:   s_d.rdata = {25'h0, s_q.raw & s_q.mask};
            default:    s_d.rdata = '0;
         endcase
      end

      // Transmit framer; starts a character only while enabled, so a disable lets it finish
      if (s_q.tick)
      begin
         case (s_q.tx_st)
            TX_IDLE:
            begin
               s_d.tx_bit = 1'b1;
               if (s_q.ctrl[`CT_EN] && s_q.ctrl[`CT_TXE] && s_q.tx_cnt != '0)
               begin
                  pop_tx = 1'b1;
                  s_d.tx_sh = s_q.tx_mem[s_q.tx_rp];
                  s_d.tx_par = ^(s_q.tx_mem[s_q.tx_rp] & wmask);
                  s_d.tx_st = TX_START;
                  s_d.tx_ph = '0;
                  s_d.tx_bit = 1'b0;
                  s_d.tx_stop2 = 1'b0;
               end
            end
            TX_START, TX_DATA, TX_PAR, TX_STOP:
            begin
               s_d.tx_ph = s_q.tx_ph + 4'h1;
               if (s_q.tx_ph == `BIT_LAST)
               begin
                  case (s_q.tx_st)
                     TX_START:
                     begin
                        s_d.tx_st = TX_DATA;
                        s_d.tx_idx = '0;
                        s_d.tx_bit = s_q.tx_sh[0];
                     end
                     TX_DATA:
                     begin
                        if (s_q.tx_idx == wlast)
                        begin
                           s_d.tx_st = lc[`LC_PEN] ? TX_PAR : TX_STOP;
                           s_d.tx_bit = lc[`LC_PEN] ?
                                        (lc[`LC_SPS] ? ~lc[`LC_EPS] : (lc[`LC_EPS] ? s_q.tx_par : ~s_q.tx_par)) :
                                        1'b1;
                        end
                        else
                        begin
                           s_d.tx_idx = 3'(s_q.tx_idx + 3'h1);
                           s_d.tx_bit = s_q.tx_sh[3'(s_q.tx_idx + 3'h1)];
                        end
                     end
                     TX_PAR:
                     begin
                        s_d.tx_st = TX_STOP;
                        s_d.tx_bit = 1'b1;
                     end
                     default:
                     begin
                        if (lc[`LC_STP2] && !s_q.tx_stop2)
                           s_d.tx_stop2 = 1'b1;
                        else
                           s_d.tx_st = TX_IDLE;
                     end
                  endcase
               end
            end
            default: s_d.tx_st = TX_IDLE;
         endcase
      end

      // Infrared decoder stretches a short low pulse over one bit time
      if (!s_q.sync2)
         s_d.sir_hold = `SIR_HOLD;
      else if (s_q.tick && s_q.sir_hold != '0)
         s_d.sir_hold = s_q.sir_hold - 5'h01;
      if (s_q.ctrl[`CT_LBE])
         rx_line = tx_line;
      else if (s_q.ctrl[`CT_SIR])
         rx_line = s_q.sync2 && (s_q.sir_hold == '0);
      else
         rx_line = s_q.sync2;

      // Receive framer
      p_exp = lc[`LC_SPS] ? ~lc[`LC_EPS] : (lc[`LC_EPS] ? ^s_q.rx_sh : ~(^s_q.rx_sh));
      // A start needs a high-to-low edge, so a line still low after a bad stop bit is no new start
      if (s_q.tick)
         s_d.rx_prev = rx_line;
      if (s_q.tick)
      begin
         case (s_q.rx_st)
            RX_IDLE:
            begin
               if (s_q.ctrl[`CT_EN] && s_q.ctrl[`CT_RXE] && s_q.rx_prev && !rx_line)
               begin
                  s_d.rx_st = RX_START;
                  s_d.rx_ph = '0;
               end
            end
            RX_START:
            begin
               s_d.rx_ph = s_q.rx_ph + 4'h1;
               if (s_q.rx_ph == `START_CHK)
               begin
                  s_d.rx_st = rx_line ? RX_IDLE : RX_DATA;
                  s_d.rx_ph = '0;
                  s_d.rx_idx = '0;
                  s_d.rx_sh = '0;
                  s_d.rx_perr = 1'b0;
               end
            end
            RX_DATA, RX_PAR, RX_STOP:
            begin
               s_d.rx_ph = s_q.rx_ph + 4'h1;
               if (s_q.rx_ph == `BIT_LAST)
               begin
                  case (s_q.rx_st)
                     RX_DATA:
                     begin
                        s_d.rx_sh[s_q.rx_idx] = rx_line;
                        s_d.rx_idx = 3'(s_q.rx_idx + 3'h1);
                        if (s_q.rx_idx == wlast)
                           s_d.rx_st = lc[`LC_PEN] ? RX_PAR : RX_STOP;
                     end
                     RX_PAR:
                     begin
                        s_d.rx_perr = (rx_line != p_exp);
                        s_d.rx_st = RX_STOP;
                     end
                     default:
                     begin
                        fe = ~rx_line;
                        be = ~rx_line && (s_q.rx_sh == '0);
                        errs = {s_q.ovr_pend, be, s_q.rx_perr & ~be, fe & ~be};
                        s_d.rx_st = RX_IDLE;
                        if (s_q.rx_cnt >= depth_eff)
                        begin
                           s_d.ovr_pend = 1'b1;
                           s_d.rstat[3] = 1'b1;
                           errs = 4'h8;
                        end
                        else
                        begin
                           push_rx = 1'b1;
                           s_d.ovr_pend = 1'b0;
                        end
                     end
                  endcase
               end
            end
            default: s_d.rx_st = RX_IDLE;
         endcase
      end

      // Queue pointers and levels
      if (push_tx)
      begin
         s_d.tx_mem[s_q.tx_wp] = wdata_i[7:0];
         s_d.tx_wp = PW'(s_q.tx_wp + 1'b1);
      end
      if (pop_tx)
         s_d.tx_rp = PW'(s_q.tx_rp + 1'b1);
      if (push_tx && !pop_tx)
         s_d.tx_cnt = CW'(s_q.tx_cnt + 1'b1);
      else if (pop_tx && !push_tx)
         s_d.tx_cnt = CW'(s_q.tx_cnt - 1'b1);
      if (push_rx)
      begin
         s_d.rx_mem[s_q.rx_wp] = {errs, s_q.rx_sh};
         s_d.rx_wp = PW'(s_q.rx_wp + 1'b1);
      end
      if (pop_rx)
         s_d.rx_rp = PW'(s_q.rx_rp + 1'b1);
      if (push_rx && !pop_rx)
         s_d.rx_cnt = CW'(s_q.rx_cnt + 1'b1);
      else if (pop_rx && !push_rx)
         s_d.rx_cnt = CW'(s_q.rx_cnt - 1'b1);

      // Receive timeout counts idle ticks while data waits
      if (s_q.rx_cnt == '0 || s_q.rx_st != RX_IDLE || pop_rx)
         s_d.to_cnt = '0;
      else if (s_q.tick && s_q.to_cnt != `RX_TIMEOUT)
         s_d.to_cnt = s_q.to_cnt + 10'h001;

      // Level events fire on reaching the threshold and drop when it is left
      s_d.rx_cond = lc[`LC_FEN] ? (s_q.rx_cnt >= level_of(s_q.thr[5:3])) : (s_q.rx_cnt != '0);
      s_d.tx_cond = lc[`LC_FEN] ? (s_q.tx_cnt <= level_of(s_q.thr[2:0])) : (s_q.tx_cnt == '0);
      s_d.raw = s_q.raw & ~clr;
      s_d.raw[`IB_RX] = s_d.rx_cond && ((s_q.raw[`IB_RX] && !clr[`IB_RX]) || !s_q.rx_cond);
      s_d.raw[`IB_TX] = s_d.tx_cond && ((s_q.raw[`IB_TX] && !clr[`IB_TX]) || !s_q.tx_cond);
      // Set wins over a clear in the same cycle
      if (s_q.tick && s_q.to_cnt == 10'(`RX_TIMEOUT - 10'h001))
         s_d.raw[`IB_RT] = 1'b1;
      s_d.raw[6:`IB_ERR] = s_d.raw[6:`IB_ERR] | errs;
      s_d.irq = |(s_d.raw & s_d.mask);

      // Infrared low-power pulse restarts at each bit boundary
      if (s_q.tick && s_d.tx_st != TX_IDLE && s_d.tx_ph == 4'h0)
         s_d.lp_left = `LP_PULSE;
      else if (s_q.lp_tick && s_q.lp_left != '0)
         s_d.lp_left = s_q.lp_left - 2'h1;

      // Line driver: plain level or infrared pulse, idle low in infrared mode
      if (s_q.ctrl[`CT_SIR])
      begin
         if (s_q.ctrl[`CT_SIRLP])
            s_d.out = ~tx_line && (s_q.lp_left != '0);
         else
            s_d.out = ~tx_line && (s_q.tx_ph < `SIR_PULSE);
      end
      else
         s_d.out = tx_line;
   end

   // State register
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         s_q <= RST_S;
      else
         s_q <= s_d;
   end

   // Outputs straight from the state register
   assign rdata_o = s_q.rdata;
   assign serial_out_o = s_q.out;
   assign irq_o = s_q.irq;
endmodule

// [logic/uart_defs.svh]
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH
// Register byte offsets
`define OFS_DATA   12'h000
`define OFS_RSTAT  12'h004
`define OFS_FLAG   12'h018
`define OFS_ILP    12'h020
`define OFS_DIVI   12'h024
`define OFS_DIVF   12'h028
`define OFS_LINE   12'h02c
`define OFS_CTRL   12'h030
`define OFS_THR    12'h034
`define OFS_MASK   12'h038
`define OFS_RAW    12'h03c
`define OFS_MIS    12'h040
`define OFS_ICLR   12'h044
// Reset values
`define CTRL_RST   10'h300
`define THR_RST    6'h12
// Line control field positions
`define LC_BRK     0
`define LC_PEN     1
`define LC_EPS     2
`define LC_STP2    3
`define LC_FEN     4
`define LC_WLEN    5
`define LC_SPS     7
// Port control field positions
`define CT_EN      0
`define CT_SIR     1
`define CT_SIRLP   2
`define CT_LBE     7
`define CT_TXE     8
`define CT_RXE     9
// Event bit positions; error events sit at 6:3 as {overrun, break, parity, framing}
`define IB_RX      0
`define IB_TX      1
`define IB_RT      2
`define IB_ERR     3
// Flag register bit positions
`define FL_BUSY    3
`define FL_RX_EMPTY_FLAG    4
`define FL_TX_FULL_FLAG    5
`define FL_RX_FULL_FLAG    6
`define FL_TX_EMPTY_FLAG    7
// Timing counts in sixteen-times ticks, low-power ticks or 1/64 clock units
`define FRAC_STEP  23'h000040
`define BIT_LAST   4'hf
`define START_CHK  4'h7
`define SIR_PULSE  4'h3
`define LP_PULSE   2'h3
`define SIR_HOLD   5'h10
`define RX_TIMEOUT 10'h1ff
`endif

// [logic/uart_pkg.sv]
package uart_pkg;
   // Transmit framing states
   typedef enum logic [4:0] {
      TX_IDLE = 5'b00001,
      TX_START = 5'b00010,
      TX_DATA = 5'b00100,
      TX_PAR = 5'b01000,
      TX_STOP = 5'b10000
   } tx_state_e;
   // Receive framing states
   typedef enum logic [4:0] {
      RX_IDLE = 5'b00001,
      RX_START = 5'b00010,
      RX_DATA = 5'b00100,
      RX_PAR = 5'b01000,
      RX_STOP = 5'b10000
   } rx_state_e;
endpackage

// [logic/unused_placeholder.sv]
`timescale 1ns/10ps

// [verification/async_serial_port_asserts.sv]
`timescale 1ns/10ps
`include "uart_defs.svh"
module serial_port_checks
#(
   parameter int DEPTH = 16
)(
   // Clock, reset and register port
   input wire logic        clock_i,
   input wire logic        srst_i,
   input wire logic [11:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   // Serial line and interrupt
   input wire logic        serial_in_i,
   input wire logic        serial_out_o,
   input wire logic        irq_o
);
   logic [15:0] divi_q;
   logic [5:0]  divf_q;
   logic        one_q;
   logic        ir_q;
   logic [6:0]  mask_q;

   // Shadow settings; bit timing is only known once a line write loads the divisor
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         divi_q <= 16'h0;
         divf_q <= 6'h0;
         one_q <= 1'b0;
         ir_q <= 1'b0;
         mask_q <= 7'h0;
      end
      else if (wr_i)
      begin
         if (addr_i == `OFS_DIVI)
            divi_q <= wdata_i[15:0];
         if (addr_i == `OFS_DIVF)
            divf_q <= wdata_i[5:0];
         if (addr_i == `OFS_LINE)
            one_q <= (divi_q == 16'h1) && (divf_q == 6'h0);
         if (addr_i == `OFS_CTRL)
            ir_q <= wdata_i[`CT_SIR];
         if (addr_i == `OFS_MASK)
            mask_q <= wdata_i[6:0];
      end
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);

   a_reset_quiet: assert property (disable iff (1'b0) srst_i |=> serial_out_o && !irq_o && rdata_o == 32'h0)
      else $error("outputs not at rest after reset");
   a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data outside read cycle");
   a_unmapped_zero: assert property (rd_i && addr_i == 12'h00c |=> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_data_width: assert property (rd_i && addr_i == `OFS_DATA |=> rdata_o[31:12] == 20'h0)
      else $error("data read wider than twelve bits");
   a_flag_consistent: assert property (rd_i && addr_i == `OFS_FLAG |=> !(rdata_o[4] && rdata_o[6]) && !(rdata_o[5] && rdata_o[7]))
      else $error("queue flags empty and full together");
   a_busy_pending: assert property (rd_i && addr_i == `OFS_FLAG |=> rdata_o[`FL_TX_EMPTY_FLAG] || rdata_o[`FL_BUSY])
      else $error("not busy with transmit data queued");
   a_start_hold: assert property (one_q && !ir_q && $fell(serial_out_o) |-> (!serial_out_o) [*8] ##1 (!serial_out_o) [*8])
      else $error("low bit shorter than sixteen ticks");
   a_high_hold: assert property (one_q && !ir_q && $rose(serial_out_o) |-> serial_out_o [*8] ##1 serial_out_o [*8])
      else $error("high bit shorter than sixteen ticks");
   a_mask_gate: assert property (mask_q == 7'h0 && $past(mask_q) == 7'h0 |-> !irq_o)
      else $error("interrupt with every event masked");
   a_masked_view: assert property (rd_i && addr_i == `OFS_MIS |=> (rdata_o & ~{25'h0, mask_q}) == 32'h0)
      else $error("masked status shows a masked event");

   // Main scenarios reached
   c_frame_error: cover property (rd_i && addr_i == `OFS_DATA ##1 rdata_o[8]);
   c_irq_raised: cover property ($rose(irq_o));
   c_tx_frame: cover property (one_q && $fell(serial_out_o));
endmodule

bind async_serial_port serial_port_checks #(.DEPTH(DEPTH)) chk_u (.clock_i(clock_i), .srst_i(srst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .serial_in_i(serial_in_i), .serial_out_o(serial_out_o), .irq_o(irq_o));

// [verification/serial_peer.sv]
`timescale 1ns/10ps
module serial_peer
#(
   parameter int BIT_CLKS = 16
)(
   // Clock
   input  wire logic clock_i,
   // Line towards the port
   output logic      line_o
);
   // Idle line rests high, as a pulled-up receive pin would
   initial line_o = 1'b1;

   // Start, data least significant first, optional parity, one stop
   task automatic send(input logic [7:0] data, input logic par_en, input logic par, input logic stop);
      logic [10:0] frame;
      int          n;
      frame = par_en ? {stop, par, data, 1'b0} : {1'b0, stop, data, 1'b0};
      n = par_en ? 11 : 10;
      for (int i = 0; i < n; i++)
      begin
         @(posedge clock_i);
         line_o <= frame[i];
         repeat (BIT_CLKS - 1) @(posedge clock_i);
      end
      @(posedge clock_i);
      line_o <= 1'b1;
   endtask

   // Short low glitch, shorter than half a bit
   task automatic pulse(input int clks);
      @(posedge clock_i);
      line_o <= 1'b0;
      repeat (clks) @(posedge clock_i);
      line_o <= 1'b1;
   endtask
endmodule

// [verification/test_async_serial_port.sv]
`timescale 1ns/10ps
`include "uart_defs.svh"
`define CHK(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module test_async_serial_port;
   logic        clock_i;
   logic        srst_i;
   logic [11:0] addr_i;
   logic [31:0] wdata_i;
   logic        wr_i;
   logic        rd_i;
   logic [31:0] rdata_o;
   logic        serial_in_i;
   logic        serial_out_o;
   logic        irq_o;
   logic [31:0] d;
   logic [9:0]  exp_frame;
   int          n_errors;
   int          samples_checked;

   async_serial_port #(.DEPTH(16)) dut_u (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_in_i(serial_in_i),
      .serial_out_o(serial_out_o), .irq_o(irq_o));
   serial_peer #(.BIT_CLKS(16)) peer_u (.clock_i(clock_i), .line_o(serial_in_i));

   // 20 MHz clock
   initial
   begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   task automatic final_report();
      if (n_errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask

   // Poll until a character waits, bounded so a dead receiver cannot hang the run
   task automatic wait_rx();
      logic [31:0] f;
      f = 32'h10;
      for (int i = 0; i < 400 && f[`FL_RX_EMPTY_FLAG] !== 1'b0; i++)
         rd(`OFS_FLAG, f);
      if (f[`FL_RX_EMPTY_FLAG] !== 1'b0)
      begin
         n_errors++;
         $display("mismatch at %0t: no character received", $time);
         final_report();
      end
   endtask

   // Reprogram only while disabled
   task automatic setup(input logic [31:0] line, input logic [31:0] ctrl);
      wr(`OFS_CTRL, 32'h300);
      wr(`OFS_LINE, line);
      wr(`OFS_CTRL, ctrl);
   endtask

   initial
   begin
      n_errors = 0;
      samples_checked = 0;
      srst_i = 1'b1;
      addr_i = 12'h0;
      wdata_i = 32'h0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      repeat (3) @(posedge clock_i);
      srst_i <= 1'b0;
      rd(`OFS_FLAG, d);
      `CHK(d, 32'h90);
      rd(`OFS_THR, d);
      `CHK(d, 32'h12);
      rd(12'h00c, d);
      `CHK(d, 32'h0);
      // Divisor of one gives a tick every clock, sixteen clocks a bit
      wr(`OFS_DIVI, 32'h1);
      wr(`OFS_DIVF, 32'h0);
      wr(`OFS_MASK, 32'h78);
      setup(32'h70, 32'h301);
      wr(`OFS_DATA, 32'h4b);
      for (int i = 0; i < 64 && serial_out_o; i++)
         @(posedge clock_i) #1;
      if (serial_out_o !== 1'b0)
      begin
         n_errors++;
         $display("mismatch at %0t: no start bit sent", $time);
         final_report();
      end
      exp_frame = {1'b1, 8'h4b, 1'b0};
      repeat (8) @(posedge clock_i);
      for (int i = 0; i < 10; i++)
      begin
         #1 `CHK(serial_out_o, exp_frame[i]);
         repeat (16) @(posedge clock_i);
      end
      rd(`OFS_FLAG, d);
      `CHK(d[`FL_BUSY], 1'b0);
      `CHK(d[`FL_TX_EMPTY_FLAG], 1'b1);
      setup(32'h70, 32'h381);
      wr(`OFS_DATA, 32'ha5);
      wr(`OFS_DATA, 32'h3c);
      rd(`OFS_FLAG, d);
      `CHK(d[`FL_BUSY], 1'b1);
      wait_rx();
      rd(`OFS_DATA, d);
      `CHK(d, 32'h0a5);
      wait_rx();
      rd(`OFS_DATA, d);
      `CHK(d, 32'h03c);
      `CHK(irq_o, 1'b0);
      setup(32'h70, 32'h301);
      peer_u.send(8'hc6, 1'b0, 1'b0, 1'b1);
      wait_rx();
      rd(`OFS_DATA, d);
      `CHK(d, 32'h0c6);
      peer_u.send(8'h81, 1'b0, 1'b0, 1'b0);
      wait_rx();
      rd(`OFS_DATA, d);
      `CHK(d, 32'h181);
      rd(`OFS_RAW, d);
      `CHK(d[3], 1'b1);
      `CHK(irq_o, 1'b1);
      rd(`OFS_MIS, d);
      `CHK(d, 32'h8);
      wr(`OFS_ICLR, 32'h78);
      rd(`OFS_RAW, d);
      `CHK(d[6:3], 4'h0);
      `CHK(irq_o, 1'b0);
      peer_u.send(8'h00, 1'b0, 1'b0, 1'b0);
      wait_rx();
      rd(`OFS_DATA, d);
      `CHK(d, 32'h400);
      peer_u.pulse(4);
      repeat (60) @(posedge clock_i);
      rd(`OFS_FLAG, d);
      `CHK(d[`FL_RX_EMPTY_FLAG], 1'b1);
      // Even parity: a wrong parity bit is flagged, a right one is not
      setup(32'h76, 32'h301);
      peer_u.send(8'h81, 1'b1, 1'b1, 1'b1);
      wait_rx();
      rd(`OFS_DATA, d);
      `CHK(d, 32'h281);
      peer_u.send(8'h81, 1'b1, 1'b0, 1'b1);
      wait_rx();
      rd(`OFS_DATA, d);
      `CHK(d, 32'h081);
      // Queues off: a second character overruns the single holding place
      setup(32'h60, 32'h301);
      peer_u.send(8'h11, 1'b0, 1'b0, 1'b1);
      wait_rx();
      rd(`OFS_FLAG, d);
      `CHK(d[`FL_RX_FULL_FLAG], 1'b1);
      peer_u.send(8'h22, 1'b0, 1'b0, 1'b1);
      repeat (20) @(posedge clock_i);
      rd(`OFS_RAW, d);
      `CHK(d[6], 1'b1);
      rd(`OFS_RSTAT, d);
      `CHK(d[3], 1'b1);
      rd(`OFS_DATA, d);
      `CHK(d[7:0], 8'h11);
      final_report();
   end
endmodule
